// [trigger_params.svh]
// Functional notes
// - flag link, code and checksum errors on every input channel.
// - error counter counts each tick with any error on any channel once.
// - sticky per-channel error type bits kept beside the count.
// - data of a channel in error is forced to zero before algorithms.
// - each algorithm gives a pass bit and an overflow bit.
// - optical result output is one 48-fibre ribbon.
// - electrical result output is 32 lvds bits, driven straight from flops.
// - inter-processor link at most 640 Mb/s per pair, bunch clock multiple.
// - input data is resynchronised into the bunch clock within one tick.
// - algorithm latency is at most five ticks from synced input to result.
// - level1_accept captures the real-time results for readout unless the event is rejected.
// - input capture is fixed or conditional on recent reception errors.
// - slices captured per accepted event are set by software.
// - captured data is buffered then serialised to the readout driver.
// - region_of_interest data leaves on its own path when enabled.
// - during busy, finish packets in progress, start no new ones.
// - during busy, formed packets are held back, not sent.
// - with no space for another event, new event data is rejected.
// - replay mode ignores live input and uses the scrolling memory.
// - replayed data enters at the algorithm input.
// - capture mode fills the scrolling memory, software reads it back.
// - result side has its own replay and capture memory, enabled apart.
// - error count readable and cleared by control, to zero, or to one if an error arrives in the clearing tick.
// - scrolling memories keep a programmable length of history.
`ifndef TRIGGER_PARAMS_SVH
`define TRIGGER_PARAMS_SVH
`define NUM_CHAN       4
`define WORD_W         16
`define CRC_W          4
`define NUM_ALGO       16
`define LVDS_W         32
`define FIBRE_W        48
`define ERR_CNT_W      16
`define ERR_CNT_MAX    16'hFFFF
`define ALGO_STAGES    5
`define CLK_PERIOD_PS  8000
`define ALGO_LIMIT_NS  125
`define ALGO_LIMIT_CYC ((`ALGO_LIMIT_NS * 1000) / `CLK_PERIOD_PS)
`define LINK_MAX_MBPS  640
`define HIST_DEPTH     16
`define HIST_AW        4
`define MAX_SLICES     8
`define SLICE_W        3
`define RO_W           64
`define ROI_W          32
`endif

// [trigger_pkg.sv]
`include "trigger_params.svh"
package trigger_pkg;
  typedef enum logic [1:0]
  {
    RO_IDLE     = 2'b00,
    RO_ASSEMBLE = 2'b01,
    RO_SEND     = 2'b11
  } ro_state_t;
  typedef logic [`NUM_CHAN*`WORD_W-1:0] chan_bus_t;
  typedef logic [`LVDS_W-1:0]           result_t;
endpackage

// [scroll_mem.sv]
`timescale 1ns/1ps
`include "trigger_params.svh"
module scroll_mem
  import trigger_pkg::*;
#(
  parameter int WIDTH = 64
)
(
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire logic                capture,
  input  wire logic [WIDTH-1:0]    live_data,
  input  wire logic [`HIST_AW-1:0] history_len,
  input  wire logic [`HIST_AW-1:0] read_addr,
  output logic      [WIDTH-1:0]    read_data,
  output logic      [WIDTH-1:0]    play_data
);
  typedef struct packed
  {
    logic [`HIST_DEPTH-1:0][WIDTH-1:0] mem;
    logic [`HIST_AW-1:0]               ptr;
    logic [WIDTH-1:0]                  rd;
    logic [WIDTH-1:0]                  play;
  } mem_state_t;
  mem_state_t s;
  mem_state_t next_s;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_s = s;
    // pointer scrolls in both modes so replay loops over the stored window
    next_s.ptr = (s.ptr >= history_len) ? '0 : s.ptr + 1'b1;
    if (capture)
      next_s.mem[s.ptr] = live_data;
    next_s.play = s.mem[s.ptr];
    next_s.rd = s.mem[read_addr];
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      s <= '0;
    else
      s <= next_s;
  end

  assign read_data = s.rd;
  assign play_data = s.play;

  ptr_wrap_a: assert property (@(posedge clock) disable iff (rst)
    s.ptr >= history_len |=> s.ptr == '0)
    else $error("history pointer did not wrap");
endmodule

// [algo_pipe.sv]
`timescale 1ns/1ps
`include "trigger_params.svh"
module algo_pipe
  import trigger_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire chan_bus_t         algo_in,
  input  wire logic [`WORD_W-1:0] threshold,
  output result_t                results
);
  typedef struct packed
  {
    logic [`ALGO_STAGES-1:0][`LVDS_W-1:0] pipe;
  } pipe_state_t;
  pipe_state_t s;
  pipe_state_t next_s;
  logic [`NUM_ALGO-1:0] pass;
  logic [`NUM_ALGO-1:0] ovf;

  ////////////////////////////////////////////////////////////////////////////
  // algorithm i looks at channel i mod NUM_CHAN, threshold staggered by i
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_ALGO; gi++)
    begin : g_algo
      logic [`WORD_W-1:0] obj;
      assign obj = algo_in[(gi % `NUM_CHAN)*`WORD_W +: `WORD_W];
      assign pass[gi] = obj > (threshold + `WORD_W'(gi));
      assign ovf[gi] = obj[`WORD_W-1];
    end
  endgenerate

  always_comb
  begin
    next_s = s;
    next_s.pipe[0] = {ovf, pass};
    for (int i = 1; i < `ALGO_STAGES; i++)
      next_s.pipe[i] = s.pipe[i-1];
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      s <= '0;
    else
      s <= next_s;
  end

  assign results = s.pipe[`ALGO_STAGES-1];

  algo_latency_a: assert property (@(posedge clock) disable iff (rst)
    results == $past({ovf, pass}, `ALGO_STAGES))
    else $error("algorithm result not five ticks after input");
endmodule

// [trigger_path.sv]
`timescale 1ns/1ps
`include "trigger_params.svh"
module trigger_path
  import trigger_pkg::*;
(
  input  wire logic                          clock,
  input  wire logic                          rst,
  input  wire chan_bus_t                     chan_data,
  input  wire logic [`NUM_CHAN-1:0]          chan_link_err,
  input  wire logic [`NUM_CHAN-1:0]          chan_code_err,
  input  wire logic [`NUM_CHAN*`CRC_W-1:0]   chan_crc,
  input  wire logic [`WORD_W-1:0]            threshold,
  input  wire logic                          error_count_clear,
  output logic      [`ERR_CNT_W-1:0]         error_count,
  output logic      [`NUM_CHAN*3-1:0]        error_detail,
  input  wire logic                          in_replay,
  input  wire logic                          in_capture,
  input  wire logic                          out_replay,
  input  wire logic                          out_capture,
  input  wire logic [`HIST_AW-1:0]           history_len,
  input  wire logic [`HIST_AW-1:0]           in_read_addr,
  output chan_bus_t                          in_read_data,
  input  wire logic [`HIST_AW-1:0]           out_read_addr,
  output result_t                            out_read_data,
  output result_t                            lvds_out,
  output logic      [`FIBRE_W-1:0]           optical_out,
  input  wire logic                          level1_accept,
  input  wire logic                          capture_on_error,
  input  wire logic                          input_capture_fixed,
  input  wire logic [`SLICE_W-1:0]           slice_count,
  input  wire logic                          roi_enable,
  input  wire logic                          readout_busy,
  output logic                               readout_valid,
  output logic      [`RO_W-1:0]              readout_data,
  output logic                               readout_last,
  output logic                               event_rejected,
  output logic                               roi_valid,
  output logic      [`ROI_W-1:0]             roi_data
);
  typedef struct packed
  {
    chan_bus_t                                 sync_data;
    logic [`NUM_CHAN-1:0]                      sync_err;
    logic [`ERR_CNT_W-1:0]                     err_cnt;
    logic [`NUM_CHAN*3-1:0]                    detail;
    logic                                      err_seen;
    logic [2:0]                                busy_sync;
    logic                                      busy;
    ro_state_t                                 state;
    logic [`MAX_SLICES-1:0][`RO_W-1:0]         pkt;
    logic [`SLICE_W-1:0]                       idx;
    logic [`SLICE_W-1:0]                       last_idx;
    logic                                      pending;
    logic                                      in_cap_on;
    logic                                      ro_valid;
    logic [`RO_W-1:0]                          ro_data;
    logic                                      ro_last;
    logic                                      rejected;
    logic                                      roi_v;
    logic [`ROI_W-1:0]                         roi_d;
    result_t                                   lvds;
  } top_state_t;
  top_state_t s;
  top_state_t next_s;

  chan_bus_t               clean_data;
  chan_bus_t               algo_in;
  chan_bus_t               in_play;
  result_t                 results;
  result_t                 out_play;
  result_t                 rt_out;
  logic [`NUM_CHAN*3-1:0]  err_now;
  logic                    any_err;
  logic                    accept_ok;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [`CRC_W-1:0] fold_crc(logic [`WORD_W-1:0] w);
    logic [`CRC_W-1:0] c;
    c = '0;
    for (int i = 0; i < `WORD_W / `CRC_W; i++)
      c = c ^ w[i*`CRC_W +: `CRC_W];
    return c;
  endfunction

  // per channel: {crc mismatch, code error, link error}
  genvar gc;
  generate
    for (gc = 0; gc < `NUM_CHAN; gc++)
    begin : g_chan
      logic crc_bad;
      assign crc_bad = fold_crc(chan_data[gc*`WORD_W +: `WORD_W])
                       != chan_crc[gc*`CRC_W +: `CRC_W];
      assign err_now[gc*3 +: 3] = {crc_bad, chan_code_err[gc],
                                   chan_link_err[gc]};
      // zeroing applies to the tick the error arrived with
      assign clean_data[gc*`WORD_W +: `WORD_W] =
        s.sync_err[gc] ? '0 : s.sync_data[gc*`WORD_W +: `WORD_W];

      zero_data_a: assert property (@(posedge clock) disable iff (rst)
        |err_now[gc*3 +: 3] |=> clean_data[gc*`WORD_W +: `WORD_W] == '0)
        else $error("erroneous channel data not zeroed");
    end
  endgenerate

  assign any_err = |err_now;
  assign algo_in = in_replay ? in_play : clean_data;
  assign rt_out = out_replay ? out_play : results;

  ////////////////////////////////////////////////////////////////////////////
  scroll_mem #(
    .WIDTH (`NUM_CHAN*`WORD_W)
  ) u_in_mem (
    .clock       (clock),
    .rst         (rst),
    .capture     (in_capture),
    .live_data   (clean_data),
    .history_len (history_len),
    .read_addr   (in_read_addr),
    .read_data   (in_read_data),
    .play_data   (in_play)
  );

  algo_pipe u_algo (
    .clock     (clock),
    .rst       (rst),
    .algo_in   (algo_in),
    .threshold (threshold),
    .results   (results)
  );

  scroll_mem #(
    .WIDTH (`LVDS_W)
  ) u_out_mem (
    .clock       (clock),
    .rst         (rst),
    .capture     (out_capture),
    .live_data   (results),
    .history_len (history_len),
    .read_addr   (out_read_addr),
    .read_data   (out_read_data),
    .play_data   (out_play)
  );

  ////////////////////////////////////////////////////////////////////////////
  assign accept_ok = level1_accept && s.state == RO_IDLE && !s.busy
                     && !s.pending;

  always_comb
  begin
    next_s = s;
    // one register stage stands for the fast-to-bunch clock resync
    next_s.sync_data = chan_data;
    for (int i = 0; i < `NUM_CHAN; i++)
      next_s.sync_err[i] = |err_now[i*3 +: 3];

    // a new error in the clearing tick still counts
    if (error_count_clear)
      next_s.err_cnt = any_err ? `ERR_CNT_W'(1) : '0;
    else if (any_err && s.err_cnt != `ERR_CNT_MAX)
      next_s.err_cnt = s.err_cnt + 1'b1;
    next_s.detail = error_count_clear ? err_now
                                      : (s.detail | err_now);

    // error history for conditional capture; reset by each accept
    next_s.err_seen = any_err || (s.err_seen && !level1_accept);

    // busy is a backplane pin: change taken once stages 2 and 3 agree
    next_s.busy_sync = {s.busy_sync[1:0], readout_busy};
    if (s.busy_sync[2] == s.busy_sync[1])
      next_s.busy = s.busy_sync[2];

    next_s.lvds = rt_out;
    next_s.ro_valid = 1'b0;
    next_s.ro_last = 1'b0;
    next_s.rejected = level1_accept && !accept_ok;
    next_s.roi_v = level1_accept && roi_enable;
    if (level1_accept && roi_enable)
      next_s.roi_d = rt_out;

    case (s.state)
      RO_IDLE:
      begin
        if (accept_ok)
        begin
          next_s.state = RO_ASSEMBLE;
          next_s.idx = '0;
          next_s.last_idx = (slice_count == '0) ? '0
                                                : slice_count - 1'b1;
          next_s.in_cap_on = input_capture_fixed
                             || (capture_on_error && s.err_seen);
        end
        else if (s.pending && !s.busy)
        begin
          next_s.state = RO_SEND;
          next_s.idx = '0;
        end
      end
      RO_ASSEMBLE:
      begin
        // assembly already begun runs on regardless of busy
        next_s.pkt[s.idx] = {rt_out,
          s.in_cap_on ? algo_in[`RO_W-`LVDS_W-1:0]
                      : {(`RO_W-`LVDS_W){1'b0}}};
        next_s.idx = s.idx + 1'b1;
        if (s.idx == s.last_idx)
        begin
          next_s.pending = 1'b1;
          next_s.state = RO_IDLE;
        end
      end
      RO_SEND:
      begin
        if (!s.busy)
        begin
          next_s.ro_valid = 1'b1;
          next_s.ro_data = s.pkt[s.idx];
          next_s.ro_last = s.idx == s.last_idx;
          next_s.idx = s.idx + 1'b1;
          if (s.idx == s.last_idx)
          begin
            next_s.pending = 1'b0;
            next_s.state = RO_IDLE;
          end
        end
      end
      default:
        next_s.state = RO_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      s <= '0;
    else
      s <= next_s;
  end

  ////////////////////////////////////////////////////////////////////////////
  assign error_count = s.err_cnt;
  assign error_detail = s.detail;
  assign lvds_out = s.lvds;
  // fibres beyond the result bits carry no data
  assign optical_out = {{(`FIBRE_W-`LVDS_W){1'b0}}, s.lvds};
  assign readout_valid = s.ro_valid;
  assign readout_data = s.ro_data;
  assign readout_last = s.ro_last;
  assign event_rejected = s.rejected;
  assign roi_valid = s.roi_v;
  assign roi_data = s.roi_d;

  ////////////////////////////////////////////////////////////////////////////
  err_count_a: assert property (@(posedge clock) disable iff (rst)
    !error_count_clear && any_err && s.err_cnt != `ERR_CNT_MAX
    |=> s.err_cnt == $past(s.err_cnt) + 1'b1)
    else $error("error count did not step");

  err_saturate_a: assert property (@(posedge clock) disable iff (rst)
    s.err_cnt == `ERR_CNT_MAX && !error_count_clear
    |=> s.err_cnt == `ERR_CNT_MAX)
    else $error("error count wrapped");

  err_clear_a: assert property (@(posedge clock) disable iff (rst)
    error_count_clear && !any_err |=> s.err_cnt == '0)
    else $error("error count not cleared");

  err_detail_a: assert property (@(posedge clock) disable iff (rst)
    !error_count_clear |=> (s.detail & $past(err_now)) == $past(err_now))
    else $error("error detail bit lost");

  busy_hold_a: assert property (@(posedge clock) disable iff (rst)
    s.busy |=> !readout_valid)
    else $error("packet sent while busy");

  no_start_a: assert property (@(posedge clock) disable iff (rst)
    s.busy && s.state == RO_IDLE |=> s.state != RO_ASSEMBLE)
    else $error("assembly started while busy");

  reject_a: assert property (@(posedge clock) disable iff (rst)
    level1_accept && s.pending |=> event_rejected)
    else $error("event not rejected with buffer full");

  lvds_follow_a: assert property (@(posedge clock) disable iff (rst)
    !out_replay |=> lvds_out == $past(results))
    else $error("electrical output not from results");

  assemble_len_a: assert property (@(posedge clock) disable iff (rst)
    s.state == RO_IDLE && accept_ok && slice_count == 3'h1
    |=> s.state == RO_ASSEMBLE ##1 s.pending)
    else $error("single slice packet not formed in one tick");

  err_idle_a: assert property (@(posedge clock) disable iff (rst)
    !any_err && !error_count_clear |=> s.err_cnt == $past(s.err_cnt))
    else $error("error count moved without an error");

  detail_clear_a: assert property (@(posedge clock) disable iff (rst)
    error_count_clear |=> s.detail == $past(err_now))
    else $error("error detail not cleared");

  sync_stage_a: assert property (@(posedge clock) disable iff (rst)
    1'b1 |=> s.sync_data == $past(chan_data))
    else $error("input not resynchronised in one tick");

  busy_filter_a: assert property (@(posedge clock) disable iff (rst)
    s.busy_sync[2] != s.busy_sync[1] |=> s.busy == $past(s.busy))
    else $error("busy changed before its filter settled");

  pending_hold_a: assert property (@(posedge clock) disable iff (rst)
    s.pending && s.busy |=> s.pending)
    else $error("formed packet released while busy");

  send_word_a: assert property (@(posedge clock) disable iff (rst)
    s.state == RO_SEND && !s.busy |=> readout_valid)
    else $error("send state gave no word");

  last_word_a: assert property (@(posedge clock) disable iff (rst)
    readout_last |-> readout_valid)
    else $error("last flag without a word");

  assemble_run_a: assert property (@(posedge clock) disable iff (rst)
    s.state == RO_ASSEMBLE && s.idx != s.last_idx |=> s.state == RO_ASSEMBLE)
    else $error("packet assembly cut short");

  accept_start_a: assert property (@(posedge clock) disable iff (rst)
    accept_ok |=> s.state == RO_ASSEMBLE && !event_rejected)
    else $error("accepted event not captured");

  reject_active_a: assert property (@(posedge clock) disable iff (rst)
    level1_accept && s.state != RO_IDLE |=> event_rejected)
    else $error("event taken while readout occupied");

  fixed_capture_a: assert property (@(posedge clock) disable iff (rst)
    accept_ok && input_capture_fixed |=> s.in_cap_on)
    else $error("fixed input capture not enabled");

  error_capture_a: assert property (@(posedge clock) disable iff (rst)
    accept_ok && capture_on_error && s.err_seen |=> s.in_cap_on)
    else $error("input capture missing after errors");

  plain_capture_a: assert property (@(posedge clock) disable iff (rst)
    accept_ok && !input_capture_fixed && !s.err_seen |=> !s.in_cap_on)
    else $error("input captured without cause");

  roi_pulse_a: assert property (@(posedge clock) disable iff (rst)
    level1_accept && roi_enable |=> roi_valid && roi_data == $past(rt_out))
    else $error("region data not forwarded");

  roi_off_a: assert property (@(posedge clock) disable iff (rst)
    !(level1_accept && roi_enable) |=> !roi_valid)
    else $error("region data sent without an accept");
endmodule

// [readout_sink.sv]
`timescale 1ns/1ps
module readout_sink
(
  input  wire logic        clock,
  input  wire logic        hold,
  input  wire logic        readout_valid,
  input  wire logic [63:0] readout_data,
  input  wire logic        readout_last,
  output logic             readout_busy,
  output int               words,
  output int               lasts,
  output logic [63:0]      head
);
  logic fresh;
  initial
  begin
    words = 0;
    lasts = 0;
    fresh = 1'b1;
    head = 64'h0;
  end
  // busy only on command; a real driver may hold it for any length
  assign readout_busy = hold;
  always @(posedge clock)
    if (readout_valid === 1'b1)
    begin
      if (fresh)
        head <= readout_data;
      fresh <= readout_last;
      words <= words + 1;
      lasts <= lasts + (readout_last ? 1 : 0);
    end
endmodule

// [tb_top.sv]
`timescale 1ns/1ps
`include "trigger_params.svh"
module tb_top
  import trigger_pkg::*;
;
  localparam chan_bus_t SAMPLE = 64'h8005004000100003;
  logic clock = 1'b0;
  logic rst = 1'b1;
  chan_bus_t chan_data, in_read_data;
  logic [3:0] chan_link_err, chan_code_err, history_len;
  logic [3:0] in_read_addr, out_read_addr;
  logic [15:0] chan_crc, threshold, error_count;
  logic [11:0] error_detail;
  logic error_count_clear, in_replay, in_capture, out_replay, out_capture;
  logic level1_accept, capture_on_error, input_capture_fixed, roi_enable;
  logic readout_busy, readout_valid, readout_last, event_rejected;
  logic roi_valid, hold;
  logic [2:0] slice_count;
  result_t out_read_data, lvds_out;
  logic [47:0] optical_out;
  logic [63:0] readout_data, head;
  logic [31:0] roi_data;
  int words, lasts, w0, l0, r0;
  int err_total = 0;
  int check_count = 0;
  int nrej = 0;
  int nroi = 0;

  trigger_path DUT (.clock, .rst, .chan_data, .chan_link_err,
    .chan_code_err, .chan_crc, .threshold, .error_count_clear,
    .error_count, .error_detail, .in_replay, .in_capture, .out_replay,
    .out_capture, .history_len, .in_read_addr, .in_read_data,
    .out_read_addr, .out_read_data, .lvds_out, .optical_out,
    .level1_accept, .capture_on_error, .input_capture_fixed,
    .slice_count, .roi_enable, .readout_busy, .readout_valid,
    .readout_data, .readout_last, .event_rejected, .roi_valid,
    .roi_data);
  readout_sink sink (.clock, .hold, .readout_valid, .readout_data,
    .readout_last, .readout_busy, .words, .lasts, .head);

  always #4 clock = ~clock;
  always @(posedge clock)
  begin
    if (event_rejected === 1'b1)
      nrej++;
    if (roi_valid === 1'b1)
      nroi++;
  end
  //////////////////////////////////////////////////////////////////////
  function automatic logic [3:0] crc_of(logic [15:0] w);
    crc_of = w[3:0] ^ w[7:4] ^ w[11:8] ^ w[15:12];
  endfunction
  // results expected from the algorithm pipe, bad channels read zero
  function automatic result_t expect_res(chan_bus_t d, logic [3:0] bad);
    logic [15:0] w;
    expect_res = '0;
    for (int i = 0; i < 16; i++)
    begin
      w = bad[i % 4] ? 16'h0000 : d[16 * (i % 4) +: 16];
      expect_res[i] = w > threshold + 16'(i);
      expect_res[16 + i] = w[15];
    end
  endfunction
  task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic ticks(int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic put(chan_bus_t d, logic [3:0] le);
    @(negedge clock);
    chan_data = d;
    chan_link_err = le;
    for (int c = 0; c < 4; c++)
      chan_crc[4 * c +: 4] = crc_of(d[16 * c +: 16]);
  endtask
  task automatic accept();
    @(negedge clock);
    level1_accept = 1'b1;
    @(negedge clock);
    level1_accept = 1'b0;
  endtask
  task automatic mark();
    w0 = words;
    l0 = lasts;
    r0 = nrej;
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  initial
  begin
    // sized for the saturation soak plus all short tests
    repeat (90000) @(posedge clock);
    err_total++;
    $display("unexpected watchdog expiry");
    tally_and_finish();
  end

  initial
  begin
    {chan_data, chan_link_err, chan_code_err, chan_crc} = '0;
    {error_count_clear, in_replay, in_capture, out_replay} = '0;
    {out_capture, level1_accept, capture_on_error, roi_enable} = '0;
    {input_capture_fixed, hold, in_read_addr, out_read_addr} = '0;
    threshold = 16'h0008;
    history_len = 4'h3;
    slice_count = 3'h2;
    ticks(10);
    rst = 1'b0;
    chk("error_count", 0, error_count);
    chk("lvds_out", 0, lvds_out);
    // errors: two channels in one tick count once
    put(SAMPLE, 4'b1100);
    ticks(1);
    chan_link_err = 4'h0;
    chan_code_err = 4'b0010;
    chk("error_count", 1, error_count);
    ticks(1);
    chan_code_err = 4'h0;
    chan_crc[3:0] = ~chan_crc[3:0];
    chk("error_count", 2, error_count);
    ticks(1);
    chan_crc[3:0] = ~chan_crc[3:0];
    chk("error_count", 3, error_count);
    chk("error_detail", 12'h254, error_detail);
    error_count_clear = 1'b1;
    ticks(1);
    error_count_clear = 1'b0;
    ticks(1);
    chk("error_count", 0, error_count);
    chk("error_detail", 0, error_detail);
    $display("error counting test finished");
    // latency, zeroing of a bad channel, one tick per result
    put(SAMPLE, 4'h0);
    put(SAMPLE, 4'b0010);
    put('0, 4'h0);
    ticks(5);
    chk("lvds_out", expect_res(SAMPLE, 0), lvds_out);
    chk("optical_out", {16'h0, expect_res(SAMPLE, 0)}, optical_out);
    ticks(1);
    chk("lvds_out", expect_res(SAMPLE, 4'b0010), lvds_out);
    ticks(1);
    chk("lvds_out", 0, lvds_out);
    $display("real-time path test finished");
    // saturation, then clear racing a fresh error
    put(SAMPLE, 4'b0001);
    ticks(65540);
    chk("error_count", 16'hFFFF, error_count);
    error_count_clear = 1'b1;
    ticks(1);
    error_count_clear = 1'b0;
    chan_link_err = 4'h0;
    chk("error_count", 1, error_count);
    $display("saturation test finished");
    // capture both memories, read back, then replay each side
    put(SAMPLE, 4'h0);
    in_capture = 1'b1;
    out_capture = 1'b1;
    ticks(20);
    in_capture = 1'b0;
    out_capture = 1'b0;
    in_read_addr = 4'h2;
    out_read_addr = 4'h2;
    ticks(1);
    chk("in_read_data", SAMPLE, in_read_data);
    chk("out_read_data", expect_res(SAMPLE, 0), out_read_data);
    in_replay = 1'b1;
    put('0, 4'h0);
    ticks(12);
    chk("lvds_out", expect_res(SAMPLE, 0), lvds_out);
    in_replay = 1'b0;
    out_replay = 1'b1;
    ticks(12);
    chk("lvds_out", expect_res(SAMPLE, 0), lvds_out);
    out_replay = 1'b0;
    $display("memory test finished");
    // readout: fixed capture, two slices, region path on
    put(SAMPLE, 4'h0);
    input_capture_fixed = 1'b1;
    roi_enable = 1'b1;
    ticks(12);
    mark();
    accept();
    ticks(12);
    chk("words", w0 + 2, words);
    chk("lasts", l0 + 1, lasts);
    chk("head", {expect_res(SAMPLE, 0), SAMPLE[31:0]}, head);
    chk("roi_count", 1, nroi);
    chk("roi_data", expect_res(SAMPLE, 0), roi_data);
    // accept held two ticks: the second lands in assembly
    mark();
    @(negedge clock);
    level1_accept = 1'b1;
    ticks(2);
    level1_accept = 1'b0;
    ticks(12);
    chk("rejects", r0 + 1, nrej);
    chk("words", w0 + 2, words);
    // busy before accept refuses the event
    hold = 1'b1;
    ticks(5);
    mark();
    accept();
    ticks(5);
    chk("rejects", r0 + 1, nrej);
    hold = 1'b0;
    ticks(5);
    // busy raised during assembly: packet formed but held back
    input_capture_fixed = 1'b0;
    capture_on_error = 1'b1;
    slice_count = 3'h7;
    mark();
    accept();
    hold = 1'b1;
    ticks(30);
    chk("words", w0, words);
    hold = 1'b0;
    ticks(20);
    chk("words", w0 + 7, words);
    chk("lasts", l0 + 1, lasts);
    chk("head", {expect_res(SAMPLE, 0), 32'h0}, head);
    // conditional capture after an error, single slice
    put(SAMPLE, 4'b0100);
    put(SAMPLE, 4'h0);
    ticks(10);
    slice_count = 3'h1;
    mark();
    accept();
    ticks(8);
    chk("words", w0 + 1, words);
    chk("lasts", l0 + 1, lasts);
    chk("head", {expect_res(SAMPLE, 0), SAMPLE[31:0]}, head);
    $display("readout test finished");
    tally_and_finish();
  end
endmodule
